// file: verilog/btg_pkg.sv
package btg_pkg;

	// Clock rates
	localparam int unsigned REF_CLK_HZ  = 200_000_000;
	localparam int unsigned SRC_CLK_HZ  = 12_000_000;
	localparam int unsigned WORK_CLK_HZ = 1_500_000;
	localparam int unsigned PHASE_UNIT  = 1_000_000;

	// Phase accumulator making the source clock enable from ref_clk
	localparam logic [7:0] PHASE_STEP = 8'(SRC_CLK_HZ / PHASE_UNIT);
	localparam logic [7:0] PHASE_MOD  = 8'(REF_CLK_HZ / PHASE_UNIT);

	// Prescaler from source clock to working clock
	localparam int unsigned PRE_DIV  = SRC_CLK_HZ / WORK_CLK_HZ;
	localparam logic [2:0]  PRE_LAST = 3'(PRE_DIV - 1);

	// Fractional dividers, kept rate over total pulses, one per note bit
	localparam int unsigned FRAC_CNT = 4;
	localparam int unsigned FRAC_NUM [FRAC_CNT] = '{101, 49, 50, 80};
	localparam int unsigned FRAC_DEN [FRAC_CNT] = '{107, 55, 63, 127};

	// Final tone divider
	localparam int unsigned TONE_DIV  = 154;
	localparam logic [7:0]  TONE_LAST = 8'(TONE_DIV - 1);
	localparam logic [7:0]  TONE_HALF = 8'(TONE_DIV / 2);

	// Register offsets
	localparam logic [3:0] OFS_FREQ = 4'h0;
	localparam logic [3:0] OFS_VOL  = 4'h4;
	localparam logic [3:0] OFS_GEN  = 4'h8;

	// Field positions
	localparam int unsigned FREQ_OCT_LSB   = 0;
	localparam int unsigned FREQ_NOTE_LSB  = 2;
	localparam int unsigned VOL_SWITCH_BIT = 0;
	localparam int unsigned VOL_LEVEL_LSB  = 1;
	localparam int unsigned GEN_CLKEN_BIT  = 0;
	localparam int unsigned GEN_BYPASS_BIT = 1;

	// Reset values
	localparam logic [3:0] NOTE_RST   = 4'h0;
	localparam logic [1:0] OCT_RST    = 2'h0;
	localparam logic [5:0] VOL_RST    = 6'h00;
	localparam logic       SWITCH_RST = 1'b0;
	localparam logic       CLKEN_RST  = 1'b0;
	localparam logic       BYPASS_RST = 1'b0;

endpackage

// file: verilog/btg_frac_div.sv
`timescale 1ns/1ps

// Pulse-dropping divider: keeps NUM of every DEN input pulses, spread evenly
module btg_frac_div
	import btg_pkg::*;
#(
	parameter int unsigned NUM = 101,
	parameter int unsigned DEN = 107
)(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Pulse stream
	input  wire logic in_en,
	input  wire logic engage,
	output logic      out_en
);

	typedef struct packed {
		logic [7:0] acc;
	} btg_fd_state_t;

	localparam logic [7:0] NUM_W = 8'(NUM);
	localparam logic [7:0] DEN_W = 8'(DEN);

	btg_fd_state_t s_q;
	btg_fd_state_t s_d;
	logic [7:0]    sum;

	// Accumulator overflow keeps a pulse; periods differ by one input period
	always_comb
	begin
		s_d = s_q;
		sum = s_q.acc + NUM_W;
		out_en = in_en;
		if (in_en && engage)
		begin
			if (sum >= DEN_W)
			begin
				s_d.acc = sum - DEN_W;
			end
			else
			begin
				s_d.acc = sum;
				out_en = 1'b0; // Dropped pulse
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

endmodule

// file: verilog/btg_top.sv
// Operation
// R01 - All tone timing derives from one 12 MHz source clock enable.
// R02 - Prescaler divides source clock to a 1500 kHz working clock.
// R03 - Four chained fractional dividers, each enabled by a note bit, else pass-through.
// R04 - Dividers drop pulses, e.g. six of every 107, evenly spread.
// R05 - Octave field selects chain output divided by 2, 4, 8 or 16.
// R06 - Multiplexer output is divided by 154 to make the tone.
// R07 - Frequency register: note in bits 5:2, octave in 1:0, reset zero.
// R08 - Software programs only valid codes, never note codes with top bits set.
// R09 - Frequency and volume writes take effect on tone clock; reads return stored value.
// R10 - General control register is written and read directly.
// R11 - General control bit 1 set bypasses the divide-by-154 stage.
// R12 - General control bit 0 enables the tone clock; off after reset.
// R13 - Six-bit volume counter on the source clock wraps after 63.
// R14 - Volume pulse high while counter is at or below volume level.
// R15 - Volume pulse high y+1 and low 63-y source periods each cycle.
// R16 - Volume register holds level in bits 6:1, reset zero; louder when larger.
// R17 - Volume register bit 0 switches tone on, reset off.
// R18 - Three 8-bit registers at offsets 0x00, 0x04 and 0x08.
// R19 - Buzzer output is tone AND volume pulse.
// R20 - Buzzer output held low while tone off or tone clock disabled.
`timescale 1ns/1ps

module btg_top
	import btg_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// Register port
	input  wire logic [3:0] reg_addr,
	input  wire logic       reg_wr_en,
	input  wire logic       reg_rd_en,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// Buzzer
	output logic            buzz_out
);

	typedef struct packed {
		logic [3:0] note_q;   // Stored as written
		logic [1:0] oct_q;
		logic [5:0] vol_q;
		logic       switch_q;
		logic       clken;
		logic       bypass;
		logic [3:0] note_a;   // Copies applied on the tone clock
		logic [1:0] oct_a;
		logic [5:0] vol_a;
		logic       switch_a;
		logic [7:0] phase;
		logic [2:0] pre_cnt;
		logic [3:0] oct_cnt;
		logic [7:0] div_cnt;
		logic       tone;
		logic [5:0] vol_cnt;
		logic       buzz;
		logic [7:0] rdata;
	} btg_state_t;

	btg_state_t s_q;
	btg_state_t s_d;

	logic [1:0]          rst_sync_q;
	logic                rst_n;
	logic [8:0]          phase_sum;
	logic                src_en;
	logic                work_en;
	logic [FRAC_CNT:0]   chain_en;
	logic [3:0]          oct_mask;
	logic                mux_en;
	logic [7:0]          div_next;
	logic                vol_pulse;
	logic [2:0]          hit;

	// Address decode, shared by write and read paths
	function automatic logic [2:0] reg_hit(input logic [3:0] a);
		reg_hit = {a == OFS_GEN, a == OFS_VOL, a == OFS_FREQ}; // [R18]
	endfunction

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_n = rst_sync_q[1];

	// Source clock enable: 12 of every 200 ref cycles, gated by clock enable
	assign phase_sum = {1'b0, s_q.phase} + {1'b0, PHASE_STEP};
	assign src_en    = (phase_sum >= {1'b0, PHASE_MOD}) && s_q.clken; // [R01] [R12]

	// Prescaler pulse once per PRE_DIV source pulses
	assign work_en = src_en && (s_q.pre_cnt == PRE_LAST); // [R02]

	// Fractional chain, divider i engaged by note bit i
	assign chain_en[0] = work_en;
	generate
		for (genvar i = 0; i < FRAC_CNT; i++)
		begin : g_frac
			btg_frac_div #(
				.NUM (FRAC_NUM[i]),
				.DEN (FRAC_DEN[i])
			) u_frac (
				.clk    (ref_clk),
				.rst_n  (rst_n),
				.in_en  (chain_en[i]),
				.engage (s_q.note_a[i]),
				.out_en (chain_en[i+1])
			); // [R03] [R04]
		end
	endgenerate

	// Octave select: pass one chain pulse in 2, 4, 8 or 16
	assign oct_mask = 4'((5'd2 << s_q.oct_a) - 5'd1);
	assign mux_en   = chain_en[FRAC_CNT] && ((s_q.oct_cnt | ~oct_mask) == 4'hF); // [R05]

	assign div_next  = (s_q.div_cnt == TONE_LAST) ? 8'h00 : s_q.div_cnt + 8'h01;
	assign vol_pulse = (s_q.vol_cnt <= s_q.vol_a); // [R14] [R15] [R16]
	assign hit       = reg_hit(reg_addr);

	// Next state of the whole block
	always_comb
	begin
		s_d = s_q;

		// Register writes; general control acts at once
		if (reg_wr_en && hit[0])
		begin
			s_d.note_q = reg_wdata[FREQ_NOTE_LSB +: 4]; // [R07]
			s_d.oct_q  = reg_wdata[FREQ_OCT_LSB +: 2];
		end
		if (reg_wr_en && hit[1])
		begin
			s_d.vol_q    = reg_wdata[VOL_LEVEL_LSB +: 6]; // [R16]
			s_d.switch_q = reg_wdata[VOL_SWITCH_BIT]; // [R17]
		end
		if (reg_wr_en && hit[2])
		begin
			s_d.clken  = reg_wdata[GEN_CLKEN_BIT]; // [R10] [R12]
			s_d.bypass = reg_wdata[GEN_BYPASS_BIT]; // [R11]
		end

		// Reads show stored copies, not the applied ones; unmapped reads zero
		if (reg_rd_en)
		begin
			if (hit[0])
				s_d.rdata = {2'b00, s_q.note_q, s_q.oct_q}; // [R09]
			else if (hit[1])
				s_d.rdata = {1'b0, s_q.vol_q, s_q.switch_q};
			else if (hit[2])
				s_d.rdata = {6'h00, s_q.bypass, s_q.clken}; // [R10]
			else
				s_d.rdata = 8'h00;
		end

		// Phase accumulator runs always so the rate stays exact
		if (phase_sum >= {1'b0, PHASE_MOD})
			s_d.phase = 8'(phase_sum - {1'b0, PHASE_MOD});
		else
			s_d.phase = phase_sum[7:0];

		// Tone clock domain: everything below moves on src_en only
		if (src_en)
		begin
			s_d.note_a   = s_q.note_q; // [R09]
			s_d.oct_a    = s_q.oct_q;
			s_d.vol_a    = s_q.vol_q;
			s_d.switch_a = s_q.switch_q;
			s_d.pre_cnt  = (s_q.pre_cnt == PRE_LAST) ? 3'h0 : s_q.pre_cnt + 3'h1; // [R02]
			s_d.vol_cnt  = s_q.vol_cnt + 6'h01; // Wraps 63 to 0 [R13]
		end

		if (chain_en[FRAC_CNT])
			s_d.oct_cnt = s_q.oct_cnt + 4'h1; // [R05]

		// Final divide by 154, or bypass with a plain toggle
		if (mux_en)
		begin
			if (s_q.bypass)
			begin
				s_d.tone = ~s_q.tone; // [R11]
			end
			else
			begin
				s_d.div_cnt = div_next; // [R06]
				s_d.tone    = (div_next < TONE_HALF);
			end
		end

		// Output: tone chopped by volume pulse, low when off or stopped
		s_d.buzz = s_q.tone && vol_pulse && s_q.switch_a && s_q.clken; // [R19] [R20] [R17]
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q          <= '0;
			s_q.note_q   <= NOTE_RST;
			s_q.oct_q    <= OCT_RST;
			s_q.vol_q    <= VOL_RST;
			s_q.switch_q <= SWITCH_RST;
			s_q.clken    <= CLKEN_RST;
			s_q.bypass   <= BYPASS_RST;
			s_q.note_a   <= NOTE_RST;
			s_q.oct_a    <= OCT_RST;
			s_q.vol_a    <= VOL_RST;
			s_q.switch_a <= SWITCH_RST;
			s_q.div_cnt  <= TONE_LAST; // Starts on the low side, so the first high run is full
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign buzz_out  = s_q.buzz;

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	property p_clk_gate;
		!s_q.clken |=> $stable(s_q.div_cnt) && $stable(s_q.tone) && $stable(s_q.oct_cnt);
	endproperty
	a_clk_gate: assert property (p_clk_gate) // [R12]
		else $error("tone clock ran while disabled");

	property p_src_rate;
		src_en |=> !src_en [*8];
	endproperty
	a_src_rate: assert property (p_src_rate) // [R01]
		else $error("source enable faster than 12 MHz");

	property p_prescale;
		work_en |-> src_en && s_q.pre_cnt == PRE_LAST ##1 s_q.pre_cnt == 3'h0;
	endproperty
	a_prescale: assert property (p_prescale) // [R02]
		else $error("working pulse not on eighth source pulse");

	property p_passthru;
		(s_q.note_a == 4'h0) |-> chain_en[FRAC_CNT] == work_en;
	endproperty
	a_passthru: assert property (p_passthru) // [R03]
		else $error("disengaged chain altered the clock");

	property p_octave;
		mux_en |-> chain_en[FRAC_CNT] && s_q.oct_cnt[0];
	endproperty
	a_octave: assert property (p_octave) // [R05]
		else $error("octave pulse off its divide-by-two slot");

	property p_div154;
		mux_en && !s_q.bypass && s_q.div_cnt == TONE_LAST |=> s_q.div_cnt == 8'h00 && s_q.tone;
	endproperty
	a_div154: assert property (p_div154) // [R06]
		else $error("final divider did not wrap at 154");

	property p_freq_read;
		reg_rd_en && reg_addr == OFS_FREQ
			|=> reg_rdata == {2'b00, $past(s_q.note_q), $past(s_q.oct_q)};
	endproperty
	a_freq_read: assert property (p_freq_read) // [R07]
		else $error("frequency read mismatch");

	property p_resync;
		reg_wr_en && reg_addr == OFS_VOL |=> ##[0:18] (s_q.vol_a == s_q.vol_q) || !s_q.clken;
	endproperty
	a_resync: assert property (p_resync) // [R09]
		else $error("volume write never applied");

	property p_gen_direct;
		reg_wr_en && reg_addr == OFS_GEN |=> s_q.clken == $past(reg_wdata[0])
			&& s_q.bypass == $past(reg_wdata[1]);
	endproperty
	a_gen_direct: assert property (p_gen_direct) // [R10]
		else $error("general control not written at once");

	property p_vol_wrap;
		src_en && s_q.vol_cnt == 6'h3F |=> s_q.vol_cnt == 6'h00;
	endproperty
	a_vol_wrap: assert property (p_vol_wrap) // [R13]
		else $error("volume counter did not wrap");

	property p_buzz_and;
		buzz_out |-> $past(s_q.tone) && $past(vol_pulse);
	endproperty
	a_buzz_and: assert property (p_buzz_and) // [R19] [R14]
		else $error("buzzer high outside tone and volume pulse");

	property p_silent;
		!s_q.switch_a || !s_q.clken |=> !buzz_out;
	endproperty
	a_silent: assert property (p_silent) // [R20] [R17]
		else $error("buzzer active while off");

	property p_freq_write;
		reg_wr_en && hit[0] |=> s_q.note_q == $past(reg_wdata[FREQ_NOTE_LSB +: 4])
			&& s_q.oct_q == $past(reg_wdata[FREQ_OCT_LSB +: 2]);
	endproperty
	a_freq_write: assert property (p_freq_write) // [R07]
		else $error("frequency write not stored");

	property p_vol_read;
		reg_rd_en && hit[1] |=> reg_rdata == {1'b0, $past(s_q.vol_q), $past(s_q.switch_q)};
	endproperty
	a_vol_read: assert property (p_vol_read) // [R09] [R16]
		else $error("volume read did not show the stored value");

	property p_gen_read;
		reg_rd_en && hit[2] |=> reg_rdata == {6'h00, $past(s_q.bypass), $past(s_q.clken)};
	endproperty
	a_gen_read: assert property (p_gen_read) // [R10]
		else $error("general control read mismatch");

	property p_unmapped;
		reg_rd_en && hit == 3'h0 |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) // [R18]
		else $error("unmapped read not zero");

	// Applied copies may only move on the tone clock
	property p_apply_hold;
		!src_en |=> $stable(s_q.note_a) && $stable(s_q.oct_a) && $stable(s_q.vol_a)
			&& $stable(s_q.switch_a);
	endproperty
	a_apply_hold: assert property (p_apply_hold) // [R09]
		else $error("register applied outside the tone clock");

	property p_vol_hold;
		!src_en |=> $stable(s_q.vol_cnt) && $stable(s_q.pre_cnt);
	endproperty
	a_vol_hold: assert property (p_vol_hold) // [R13] [R15]
		else $error("volume counter moved off the source clock");

	property p_bypass;
		mux_en && s_q.bypass |=> s_q.tone != $past(s_q.tone) && $stable(s_q.div_cnt);
	endproperty
	a_bypass: assert property (p_bypass) // [R11]
		else $error("bypassed stage did not toggle");

	c_buzz_on: cover property ($rose(buzz_out));
	c_bypass: cover property (mux_en && s_q.bypass);
	c_top_note: cover property (mux_en && s_q.note_a == 4'hB && s_q.oct_a == 2'h3);
	c_full_vol: cover property (s_q.vol_a == 6'h3F && buzz_out);

endmodule

// file: verification/btg_buzzer_model.sv
`timescale 1ns/1ps

// Buzzer load: tallies rising drive edges and on-time since the last clear
module btg_buzzer_model
(
	// Clock and drive
	input  wire logic ref_clk,
	input  wire logic drive,
	input  wire logic clr,
	// Observed figures
	output int        rises,
	output int        highs
);
	logic last;

	// A real load only sees the average, so count rather than sample
	always_ff @(posedge ref_clk)
	begin
		last <= drive;
		if (clr)
		begin
			rises <= 0;
			highs <= 0;
		end
		else
		begin
			rises <= rises + int'(drive && !last);
			highs <= highs + int'(drive);
		end
	end
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps

module testbench;
	import btg_pkg::*;
	logic       ref_clk;
	logic       nrst;
	logic [3:0] reg_addr;
	logic       reg_wr_en;
	logic       reg_rd_en;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       buzz_out;
	logic       clr;
	int         rises;
	int         highs;
	int         err_total;
	int         n_tests;
	int         cyc;

	btg_top i_dut (
		.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .buzz_out(buzz_out));
	btg_buzzer_model i_load (
		.ref_clk(ref_clk), .drive(buzz_out), .clr(clr),
		.rises(rises), .highs(highs));

	// 200 MHz clock and a cycle count for spans
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		cyc <= cyc + 1;

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t read %h expected %h", $time, got, exp);
		end
	endtask

	// Counts carry jitter of the source enable, hence a tolerance
	task automatic chkn(input int got, input int exp, input int tol);
		n_tests++;
		if (got < exp - tol || got > exp + tol)
		begin
			err_total++;
			$display("BAD %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge ref_clk);
		reg_wr_en <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_rd_en <= 1'b1;
		@(posedge ref_clk);
		reg_rd_en <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk8(reg_rdata, e);
	endtask

	// Settle past the source enable, clear the tally, run n cycles
	task automatic win(input int n);
		repeat (40) @(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic t_reset_vals;
		rd_chk(OFS_FREQ, 8'h00);
		rd_chk(OFS_VOL, 8'h00);
		rd_chk(OFS_GEN, 8'h00);
		rd_chk(4'hC, 8'h00);
	endtask

	// High half of note 0 octave 0, volume swept inside it
	task automatic t_tone_vol;
		int t0;
		int y;
		wr(OFS_VOL, 8'h7F);
		wr(OFS_FREQ, 8'h00);
		wr(OFS_GEN, 8'h01);
		// Sample a settled output, not the edge that launches it
		for (t0 = 0; t0 < 45000 && buzz_out !== 1'b1; t0++)
		begin
			@(posedge ref_clk);
			#1;
		end
		t0 = cyc;
		for (y = 0; y < 63; y += 31)
		begin
			wr(OFS_VOL, 8'((y << 1) | 1));
			win(3200);
			chkn(highs, (y + 1) * 50, 20);
		end
		wr(OFS_VOL, 8'h7F);
		repeat (40) @(posedge ref_clk);
		for (y = 0; y < 25000 && buzz_out !== 1'b0; y++)
		begin
			@(posedge ref_clk);
			#1;
		end
		chkn(cyc - t0, TONE_DIV * 400 / 3, 60);
	endtask

	// Switch and clock enable each silence the output
	task automatic t_off;
		wr(OFS_GEN, 8'h03);
		wr(OFS_VOL, 8'h7E);
		win(2000);
		chkn(highs, 0, 0);
		wr(OFS_VOL, 8'h7F);
		wr(OFS_GEN, 8'h02);
		win(2000);
		chkn(highs, 0, 0);
	endtask

	// Final stage bypassed: square at half the octave pulse rate
	task automatic t_octaves;
		int k;
		wr(OFS_GEN, 8'h03);
		for (k = 0; k < 4; k++)
		begin
			wr(OFS_FREQ, 8'(k));
			win(6400);
			chkn(rises, 12 >> k, 1);
		end
	endtask

	// One divider at a time; only valid note codes are written
	task automatic t_notes;
		int i;
		for (i = 0; i < 4; i++)
		begin
			wr(OFS_FREQ, 8'(4 << i));
			win(6400);
			chkn(rises, (12 * FRAC_NUM[i] + FRAC_DEN[i] / 2) / FRAC_DEN[i], 1);
		end
	endtask

	// Stored values read back with the tone clock off
	task automatic t_regs;
		wr(OFS_GEN, 8'hFC);
		rd_chk(OFS_GEN, 8'h00);
		wr(OFS_FREQ, 8'h2F);
		rd_chk(OFS_FREQ, 8'h2F);
		wr(OFS_VOL, 8'hFF);
		rd_chk(OFS_VOL, 8'h7F);
		wr(4'hC, 8'hFF);
		rd_chk(4'hC, 8'h00);
		wr(OFS_GEN, 8'hFF);
		rd_chk(OFS_GEN, 8'h03);
	endtask

	initial
	begin
		nrst = 1'b0;
		reg_addr = 4'h0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 8'h00;
		clr = 1'b0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset_vals;
		t_tone_vol;
		t_off;
		t_octaves;
		t_notes;
		t_regs;
		end_of_test;
	end

	// Tests take about 77k cycles; a hang stops short of 100k
	initial
	begin
		repeat (95000) @(posedge ref_clk);
		err_total++;
		end_of_test;
	end
endmodule
